// >>> rssl_consts.svh
// Register offsets, field positions and reset values for the resource status block
`ifndef RSSL_CONSTS_SVH
`define RSSL_CONSTS_SVH
`define RSSL_OFF_ERR        12'h000
`define RSSL_OFF_STATE      12'h004
`define RSSL_OFF_CTRL       12'h008
`define RSSL_OFF_LOCK       12'h00C
`define RSSL_OFF_MODES      12'h010
`define RSSL_OFF_ID         12'h014
`define RSSL_ERR_OTHER      0
`define RSSL_ERR_CFG        1
`define RSSL_ERR_SIM        3
`define RSSL_ERR_MAINT      6
`define RSSL_ERR_MEM        9
`define RSSL_ERR_STATIC     10
`define RSSL_ERR_NV         11
`define RSSL_ERR_FAILED     13
`define RSSL_ERR_PWRUP      14
`define RSSL_ERR_OOS        15
`define RSSL_CTRL_OOS       0
`define RSSL_CTRL_SWL_FEAT  1
`define RSSL_CTRL_CFG_BAD   2
`define RSSL_CTRL_OPER      3
`define RSSL_CTRL_UPPER     4
`define RSSL_CTRL_RESET     5'h01
`define RSSL_LOCK_RESET     1'h0
`define RSSL_ID_VALUE       16'hA5C3 // Arbitrary identification value
`endif

// >>> rssl_pkg.sv
// Types shared by the resource status block
package rssl_pkg;
	typedef enum logic [3:0] {
		RSSL_INIT    = 4'h1,
		RSSL_ONLINE  = 4'h2,
		RSSL_STANDBY = 4'h4,
		RSSL_FAILURE = 4'h8
	} rssl_state_type;
	typedef enum logic [1:0] {
		RSSL_M_INITIALIZATION_MANUAL_MODE = 2'h0,
		RSSL_M_AUTO = 2'h1,
		RSSL_M_UPPER = 2'h2,
		RSSL_M_OOS  = 2'h3
	} rssl_mode_type;
endpackage

// >>> rssl_top.sv
// Resource status, operating state machine and write lock with APB access
//
// Contract
// - Error bit 0 set while a device initialization error is present.
// - Error bit 1 set when feature, cycle select or cycle kind is invalid.
// - Error bit 3 set while the simulation jumper is fitted.
// - Error bits 2, 4, 5, 7, 8 and 12 always read zero.
// - Error bit 6 set while any maintenance alert is active.
// - Error bit 13 set while any failed alert is active.
// - Bits 9, 10, 11 flag pending flash, static and NV memory failures.
// - Bit 14 set after power-up until the block runs normally.
// - Bit 15 set whenever resource actual mode is out of service.
// - Readable operating state is exactly one of four states.
// - Restart enters initialization, also out of failure; blocks held in init-manual.
// - In initialization, unreported block alarms are acknowledged automatically.
// - Once operational, schedule execution and go from init to online.
// - Online places blocks in auto, then permits a higher mode.
// - Resource out of service gives standby; blocks forced OUT_OF_SERVICE_MODE, transducer kept.
// - Resource mode to auto in standby returns to online.
// - Hardware or memory failure gives failure state; all modes OUT_OF_SERVICE_MODE.
// - Write lock honoured only when soft write lock feature is selected.
// - While locked, reject all writes except unlocking the write lock.
// - While locked, the block keeps updating and executing normally.
// - Write alarm active whenever write lock is not locked.
`include "rssl_consts.svh"

module rssl_top
	import rssl_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Device condition inputs
	input  wire logic        restart_i,
	input  wire logic        init_error_i,
	input  wire logic        sim_jumper_i,
	input  wire logic        maint_alert_i,
	input  wire logic        failed_alert_i,
	input  wire logic        mem_pending_i,
	input  wire logic        static_mem_fail_i,
	input  wire logic        nv_mem_fail_i,
	input  wire logic        hw_fail_i,
	input  wire logic        unreported_alarm_i,
	// Block supervision outputs
	output logic [15:0]      resource_error_conditions_o,
	output logic [1:0]       device_operating_state_o,
	output logic [1:0]       fb_mode_o,
	output logic             tb_force_oos_o,
	output logic             sched_run_o,
	output logic             alarm_ack_o,
	output logic             write_alarm_o,
	output logic             write_locked_o
);

	rssl_state_type state_reg;
	rssl_state_type state_next;
	logic [4:0]     ctrl_reg;
	logic           lock_reg;
	logic           pwr_up_reg;
	logic           mem_fail;
	logic           locked;
	logic           acc;
	logic           wr_ok;
	logic [15:0]    err_vec;
	logic [31:0]    rd_data;
	logic           mapped;

	// Decoding shared by the write guard and the error response
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `RSSL_OFF_ERR) || (a == `RSSL_OFF_STATE) ||
			(a == `RSSL_OFF_CTRL) || (a == `RSSL_OFF_LOCK) ||
			(a == `RSSL_OFF_MODES) || (a == `RSSL_OFF_ID);
	endfunction

	function automatic logic [1:0] state_code(input rssl_state_type s);
		case (s)
			RSSL_INIT:    state_code = 2'h0;
			RSSL_ONLINE:  state_code = 2'h1;
			RSSL_STANDBY: state_code = 2'h2;
			RSSL_FAILURE: state_code = 2'h3;
			default:      state_code = 2'h0;
		endcase
	endfunction

	// A locked device lets through only the write that unlocks it
	function automatic logic lock_refuses(input logic lk,
		input logic [11:0] a, input logic d0);
		lock_refuses = lk && !(a == `RSSL_OFF_LOCK && !d0);
	endfunction

	// Status, state, modes and identity are never written by software
	function automatic logic is_read_only(input logic [11:0] a);
		is_read_only = (a == `RSSL_OFF_ERR) || (a == `RSSL_OFF_STATE) ||
			(a == `RSSL_OFF_MODES) || (a == `RSSL_OFF_ID);
	endfunction

	assign mem_fail = static_mem_fail_i | nv_mem_fail_i | hw_fail_i;
	assign locked   = lock_reg & ctrl_reg[`RSSL_CTRL_SWL_FEAT];
	assign acc      = psel_i & penable_i & pready_o;
	assign mapped   = is_mapped(paddr_i);

	// Only an unlock write passes the guard while locked
	always_comb begin
		wr_ok = acc & pwrite_i & mapped;
		if (lock_refuses(locked, paddr_i, pwdata_i[0])) begin
			wr_ok = 1'b0;
		end
	end

	// Error vector; unused bits stay zero
	always_comb begin
		err_vec = 16'h0000;
		err_vec[`RSSL_ERR_OTHER]  = init_error_i;
		err_vec[`RSSL_ERR_CFG]    = ctrl_reg[`RSSL_CTRL_CFG_BAD];
		err_vec[`RSSL_ERR_SIM]    = sim_jumper_i;
		err_vec[`RSSL_ERR_MAINT]  = maint_alert_i;
		err_vec[`RSSL_ERR_MEM]    = mem_pending_i;
		err_vec[`RSSL_ERR_STATIC] = static_mem_fail_i;
		err_vec[`RSSL_ERR_NV]     = nv_mem_fail_i;
		err_vec[`RSSL_ERR_FAILED] = failed_alert_i;
		err_vec[`RSSL_ERR_PWRUP]  = pwr_up_reg;
		err_vec[`RSSL_ERR_OOS]    = ctrl_reg[`RSSL_CTRL_OOS];
	end

	// Operating state transitions; restart outranks failure, which outranks everything else
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RSSL_INIT: begin
				if (ctrl_reg[`RSSL_CTRL_OPER] && !init_error_i) begin
					state_next = ctrl_reg[`RSSL_CTRL_OOS] ? RSSL_STANDBY
						: RSSL_ONLINE;
				end
			end
			RSSL_ONLINE: begin
				if (ctrl_reg[`RSSL_CTRL_OOS]) begin
					state_next = RSSL_STANDBY;
				end
			end
			RSSL_STANDBY: begin
				if (!ctrl_reg[`RSSL_CTRL_OOS]) begin
					state_next = RSSL_ONLINE;
				end
			end
			RSSL_FAILURE: begin
				state_next = RSSL_FAILURE;
			end
			default: state_next = RSSL_INIT;
		endcase
		if (mem_fail) begin
			state_next = RSSL_FAILURE;
		end
		if (restart_i) begin
			state_next = RSSL_INIT;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg <= RSSL_INIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Power-up flag clears once the block first runs online
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			pwr_up_reg <= 1'b1;
		end else if (restart_i) begin
			pwr_up_reg <= 1'b1;
		end else if (state_reg == RSSL_ONLINE) begin
			pwr_up_reg <= 1'b0;
		end
	end

	// Control register; the lock never blocks status or state updates
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			ctrl_reg <= `RSSL_CTRL_RESET;
		end else if (wr_ok && paddr_i == `RSSL_OFF_CTRL) begin
			ctrl_reg <= pwdata_i[4:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			lock_reg <= `RSSL_LOCK_RESET;
		end else if (wr_ok && paddr_i == `RSSL_OFF_LOCK) begin
			lock_reg <= pwdata_i[0];
		end
	end

	// Block mode outputs follow the state
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			fb_mode_o      <= RSSL_M_INITIALIZATION_MANUAL_MODE;
			tb_force_oos_o <= 1'b0;
			sched_run_o    <= 1'b0;
			alarm_ack_o    <= 1'b0;
		end else begin
			tb_force_oos_o <= (state_reg == RSSL_FAILURE);
			sched_run_o    <= (state_reg == RSSL_ONLINE);
			alarm_ack_o    <= (state_reg == RSSL_INIT) &&
				unreported_alarm_i;
			case (state_reg)
				RSSL_INIT:    fb_mode_o <= RSSL_M_INITIALIZATION_MANUAL_MODE;
				RSSL_ONLINE:  fb_mode_o <= ctrl_reg[`RSSL_CTRL_UPPER] ?
					RSSL_M_UPPER : RSSL_M_AUTO;
				RSSL_STANDBY: fb_mode_o <= RSSL_M_OOS;
				RSSL_FAILURE: fb_mode_o <= RSSL_M_OOS;
				default:      fb_mode_o <= RSSL_M_INITIALIZATION_MANUAL_MODE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			resource_error_conditions_o <= 16'h0000;
			device_operating_state_o    <= 2'h0;
			write_alarm_o               <= 1'b0;
			write_locked_o              <= 1'b0;
		end else begin
			resource_error_conditions_o <= err_vec;
			device_operating_state_o    <= state_code(state_reg);
			write_alarm_o               <= !locked;
			write_locked_o              <= locked;
		end
	end

	// Read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr_i)
			`RSSL_OFF_ERR:   rd_data = {16'h0000, err_vec};
			`RSSL_OFF_STATE: rd_data = {30'h0, state_code(state_reg)};
			`RSSL_OFF_CTRL:  rd_data = {27'h0, ctrl_reg};
			`RSSL_OFF_LOCK:  rd_data = {30'h0, locked, lock_reg};
			`RSSL_OFF_MODES: rd_data = {29'h0, tb_force_oos_o, fb_mode_o};
			`RSSL_OFF_ID:    rd_data = {16'h0000, `RSSL_ID_VALUE};
			default:         rd_data = 32'h0000_0000;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (psel_i && penable_i && !pready_o) begin
			pready_o  <= 1'b1;
			prdata_o  <= rd_data;
			pslverr_o <= !mapped || (pwrite_i &&
				(lock_refuses(locked, paddr_i, pwdata_i[0]) ||
				is_read_only(paddr_i)));
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule // rssl_top

// >>> rssl_checker.sv
// Assertion checker for the resource status block
module rssl_checker (
	input wire logic        ref_clk_i, nrst_i, psel_i, penable_i,
	input wire logic        restart_i, sim_jumper_i, maint_alert_i,
	input wire logic        failed_alert_i, hw_fail_i, pready_o, pslverr_o,
	input wire logic        tb_force_oos_o, write_alarm_o, write_locked_o,
	input wire logic [15:0] resource_error_conditions_o,
	input wire logic [1:0]  device_operating_state_o, fb_mode_o
);
	wire [15:0] e = resource_error_conditions_o;
	wire [1:0]  st = device_operating_state_o;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_access; psel_i && penable_i; endsequence
	a_sim_bit: assert property ($past(nrst_i) |-> e[3] == $past(sim_jumper_i))
		else $error("simulation bit wrong");
	a_alert_bits: assert property ($past(nrst_i) |->
		e[6] == $past(maint_alert_i) && e[13] == $past(failed_alert_i))
		else $error("alert bits wrong");
	a_unused_zero: assert property ((e & 16'h11B4) == 16'h0000)
		else $error("unused error bit set");
	a_fail_entry: assert property (hw_fail_i && !restart_i ##1 !restart_i
		|-> ##[0:1] st == 2'h3) else $error("failure state missed");
	a_fail_modes: assert property ($rose(st == 2'h3) |-> ##[0:2]
		(fb_mode_o == 2'h3 && tb_force_oos_o)) else $error("modes not forced");
	a_lock_alarm: assert property ($past(nrst_i) |->
		write_alarm_o == !write_locked_o) else $error("write alarm wrong");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_slot: assert property (s_setup ##1 s_access |=> pready_o)
		else $error("ready not in second access cycle");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
endmodule // rssl_checker

bind rssl_top rssl_checker i_chk (.ref_clk_i, .nrst_i, .psel_i, .penable_i,
	.restart_i, .sim_jumper_i, .maint_alert_i, .failed_alert_i, .hw_fail_i,
	.pready_o, .pslverr_o, .tb_force_oos_o, .write_alarm_o, .write_locked_o,
	.resource_error_conditions_o, .device_operating_state_o, .fb_mode_o);

// >>> rssl_host.sv
// Host model: APB master reaching the block's registers
module rssl_host (
	input  wire logic        clk_i, pready_i, pslverr_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o, penable_o, pwrite_o,
	output logic      [11:0] paddr_o,
	output logic      [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{psel_o, penable_o, pwrite_o} = 3'h0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end
	// Request held until ready is sampled; data bus inverted once released
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		q = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
	endtask
endmodule // rssl_host

// >>> resource_status_state_lock_test.sv
// Self-checking bench for the resource status block
module resource_status_state_lock_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 0, nrst_i = 0, restart_i = 0, init_error_i = 0;
	logic sim_jumper_i = 0, maint_alert_i = 0, failed_alert_i = 0;
	logic mem_pending_i = 0, static_mem_fail_i = 0, nv_mem_fail_i = 0;
	logic hw_fail_i = 0, unreported_alarm_i = 0;
	logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [15:0] resource_error_conditions_o;
	logic [1:0]  device_operating_state_o, fb_mode_o;
	logic tb_force_oos_o, sched_run_o, alarm_ack_o;
	logic write_alarm_o, write_locked_o;
	int   miscompares = 0, n_checks = 0, cyc = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	rssl_top i_dut (.*);
	rssl_host i_host (.clk_i(ref_clk_i), .pready_i(pready_o),
		.pslverr_i(pslverr_o), .prdata_i(prdata_o), .psel_o(psel_i),
		.penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] ex);
		logic [31:0] q;
		logic        e;
		i_host.xfer(1'b0, a, 32'h0, q, e);
		chk(q, ex);
		chk({31'h0, e}, 32'h0);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] q;
		logic        e;
		i_host.xfer(1'b1, a, d, q, e);
		chk({31'h0, e}, {31'h0, ee});
	endtask
	task tick;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask
	task outs(input logic [1:0] s, input logic [1:0] m, input logic t);
		chk({27'h0, device_operating_state_o, fb_mode_o, tb_force_oos_o},
			{27'h0, s, m, t});
	endtask
	// Error vector while in init: power-up and out-of-service bits stand
	function logic [15:0] exp_err(input logic [4:0] r);
		return {2'b11, r[4], 3'b0, r[3], 2'b0, r[2], 2'b0, r[1], 2'b0, r[0]};
	endfunction
	initial begin
		logic [4:0] r;
		r = 5'($urandom(54487));
		repeat (4) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rd(12'h014, 32'h0000A5C3);
		rd(12'h000, 32'h0000C000);
		rd(12'h004, 32'h0);
		wr(12'h018, 32'h1, 1'b1);
		wr(12'h000, 32'h1, 1'b1);
		$display("test registers done");
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk_i);
			r = (i == 0) ? 5'h1F : 5'($urandom);
			{failed_alert_i, mem_pending_i, maint_alert_i, sim_jumper_i,
				init_error_i} <= r;
			tick;
			chk({16'h0, resource_error_conditions_o}, {16'h0, exp_err(r)});
		end
		{failed_alert_i, mem_pending_i, maint_alert_i, sim_jumper_i,
			init_error_i} <= 5'h00;
		$display("test error vector done");
		wr(12'h008, 32'h0C, 1'b0);
		tick;
		outs(2'h1, 2'h1, 1'b0);
		chk({31'h0, sched_run_o}, 32'h1);
		chk({16'h0, resource_error_conditions_o}, 32'h0002);
		wr(12'h008, 32'h09, 1'b0);
		tick;
		outs(2'h2, 2'h3, 1'b0);
		chk({16'h0, resource_error_conditions_o}, 32'h8000);
		wr(12'h008, 32'h08, 1'b0);
		tick;
		outs(2'h1, 2'h1, 1'b0);
		unreported_alarm_i <= 1'b1;
		wr(12'h008, 32'h18, 1'b0);
		tick;
		outs(2'h1, 2'h2, 1'b0);
		rd(12'h010, 32'h2);
		rd(12'h004, 32'h1);
		chk({31'h0, alarm_ack_o}, 32'h0);
		$display("test states done");
		wr(12'h00C, 32'h1, 1'b0);
		rd(12'h00C, 32'h1);
		wr(12'h008, 32'h0A, 1'b0);
		tick;
		chk({30'h0, write_locked_o, write_alarm_o}, 32'h2);
		wr(12'h008, 32'h09, 1'b1);
		tick;
		outs(2'h1, 2'h1, 1'b0);
		sim_jumper_i <= 1'b1;
		tick;
		chk({16'h0, resource_error_conditions_o}, 32'h0008);
		sim_jumper_i <= 1'b0;
		wr(12'h00C, 32'h0, 1'b0);
		tick;
		chk({30'h0, write_locked_o, write_alarm_o}, 32'h1);
		$display("test lock done");
		wr(12'h008, 32'h02, 1'b0);
		@(posedge ref_clk_i);
		hw_fail_i <= 1'b1;
		tick;
		outs(2'h3, 2'h3, 1'b1);
		@(posedge ref_clk_i);
		hw_fail_i <= 1'b0;
		restart_i <= 1'b1;
		@(posedge ref_clk_i);
		restart_i <= 1'b0;
		unreported_alarm_i <= 1'b1;
		tick;
		outs(2'h0, 2'h0, 1'b0);
		chk({31'h0, alarm_ack_o}, 32'h1);
		static_mem_fail_i <= 1'b1;
		tick;
		chk({16'h0, resource_error_conditions_o}, 32'h4400);
		outs(2'h3, 2'h3, 1'b1);
		static_mem_fail_i <= 1'b0;
		nv_mem_fail_i <= 1'b1;
		tick;
		chk({16'h0, resource_error_conditions_o}, 32'h4800);
		chk({31'h0, alarm_ack_o}, 32'h0);
		chk({31'h0, sched_run_o}, 32'h0);
		$display("test failure done");
		tally_and_finish;
	end
endmodule // resource_status_state_lock_test
